// ### sts3c_poh_tx_map.svh
// Purpose: Register indexes, field positions, reset values and frame figures
//          for the STS-3c transmit path overhead generator.
// Assumes: Register indexes are word indexes; byte address is four times the index.
// Notes:   Included by the top module and the testbench.
//
// Function
// - First SPE column is nine-byte path overhead
// - ATM cell bytes fill SPE payload positions
// - BIP-8 of each SPE goes into next B3
// - Sent B3 is parity XOR error mask
// - Error mask resets to zero
// - Control byte 0 bit 0 enables path AIS
// - Path AIS forces SPE and pointers all ones
// - No cells or packets sent during AIS
// - RDI from auto, software or external input
// - Auto RDI follows six receive defects
// - RDI type 00 selects automatic insertion
// - Auto RDI code goes to G1 bits 5-7
// - PLM code field bits 3:1 of byte 2
// - Byte 2 bit 0 enables RDI on PLM
// - J1, H4, Z3-Z5 from configuration; C2, F2 from configuration or ext_poh_byte
// - REI sent automatically or by software
// - Software forces pointer and NDF events
// - H4 carries no multiframe content
// - Auto REI reports receive B3 errors
// - PPP packets map into SPE instead of cells
`ifndef STS3C_POH_TX_MAP_SVH
`define STS3C_POH_TX_MAP_SVH

`define POH_IDX_CTRL0 14'h1983
`define POH_IDX_B3_MASK 14'h1997
`define POH_IDX_RDI_CODE2 14'h19c9
`define POH_IDX_RDI_CODE1 14'h19ca
`define POH_IDX_RDI_CODE0 14'h19cb
`define POH_IDX_BYTES_A 14'h19e0
`define POH_IDX_BYTES_B 14'h19e1
`define POH_IDX_FORCE 14'h19e2
`define POH_IDX_STATUS 14'h19e3

`define POH_CTRL0_AIS 0
`define POH_CTRL0_C2_TYPE 2
`define POH_CTRL0_RDI_LSB 3
`define POH_CTRL0_REI_LSB 5
`define POH_CTRL0_F2_TYPE 7
`define POH_CTRL0_RW_MASK 8'hfd

`define POH_FORCE_INC 0
`define POH_FORCE_DEC 1
`define POH_FORCE_NDF 2
`define POH_FORCE_NDF_CONT 3
`define POH_FORCE_PPP 4

`define POH_RST_CTRL0 8'h00
`define POH_RST_B3_MASK 8'h00
`define POH_RST_RDI_CODE 8'h00
`define POH_RST_BYTES_A 32'h00010000
`define POH_RST_BYTES_B 32'h00000000

`define POH_ROWS 9
`define POH_COLS 261
`define POH_FILL_BYTE 8'h00
`define POH_REI_MAX 4'h8

`endif

// ### sts3c_poh_tx_pkg.sv
// Purpose: Types shared by the STS-3c transmit path overhead generator.
// Assumes: Numeric constants live in sts3c_poh_tx_map.svh.
// Notes:   Defect vector order sets auto RDI priority, bit 0 highest.
`default_nettype none
package sts3c_poh_tx_pkg;

	// Bit 0 is path AIS, the most severe defect
	typedef struct packed {
		logic lcd;
		logic plm;
		logic tim;
		logic uneq;
		logic lop;
		logic ais;
	} rx_defects_t;

	typedef struct packed {
		logic valid;
		logic sof;
		logic poh;
		logic [7:0] data;
	} spe_out_t;

	typedef struct packed {
		logic inc;
		logic dec;
		logic ndf;
	} ptr_cmd_t;

endpackage : sts3c_poh_tx_pkg
`default_nettype wire

// ### sts3c_path_overhead_tx.sv
// Purpose: STS-3c transmit path overhead generator with APB register access.
// Assumes: One SPE byte per pclk; upstream and receive-side inputs share pclk.
// Notes:   Control, mask and RDI code registers are byte wide in the low bits; bytes A, B and status use the whole APB word.
`timescale 1ns/10ps
`default_nettype none
`include "sts3c_poh_tx_map.svh"

module sts3c_path_overhead_tx #(
	parameter int ROWS = `POH_ROWS,
	parameter int COLS = `POH_COLS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] atm_data,
	input wire logic atm_valid,
	output logic atm_ready,
	input wire logic [7:0] ppp_data,
	input wire logic ppp_valid,
	output logic ppp_ready,
	input wire sts3c_poh_tx_pkg::rx_defects_t rx_defects,
	input wire logic [3:0] rx_b3_err_cnt,
	input wire logic rx_b3_err_stb,
	input wire logic ext_path_overhead_in,
	input wire logic [7:0] ext_poh_byte,
	output sts3c_poh_tx_pkg::spe_out_t spe_out,
	output logic ptr_ais,
	output sts3c_poh_tx_pkg::ptr_cmd_t ptr_cmd
);

	logic [7:0] ctrl0_q;
	logic [7:0] b3_mask_q;
	logic [23:0] rdi_code_q;
	logic [31:0] bytes_a_q;
	logic [31:0] bytes_b_q;
	logic [4:0] force_q;
	logic [2:0] pend_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic ext_sync1_q;
	logic ext_sync2_q;
	logic [3:0] row_q;
	logic [8:0] col_q;
	logic [7:0] acc_q;
	logic [7:0] b3_q;
	logic [3:0] rei_cnt_q;
	logic atm_ready_q;
	logic ppp_ready_q;
	sts3c_poh_tx_pkg::spe_out_t spe_out_q;
	sts3c_poh_tx_pkg::ptr_cmd_t ptr_cmd_q;
	logic ptr_ais_q;

	logic setup;
	logic wr_en;
	logic [13:0] idx;
	logic hit;
	logic [31:0] rd_word;
	logic ais_q;
	logic ais_next;
	logic last_col;
	logic last_row;
	logic frame_end;
	logic sof;
	logic [3:0] row_d;
	logic [8:0] col_d;
	logic [3:0] auto_rdi;
	logic [2:0] rdi_val;
	logic [3:0] rei_val;
	logic [7:0] g1_byte;
	logic [7:0] poh_byte;
	logic [7:0] byte_d;
	logic take_atm;
	logic take_ppp;

	// Highest-priority enabled defect; each defect owns a 4-bit slot {code, enable}
	function automatic logic [3:0] pick_rdi(input logic [5:0] d, input logic [23:0] r);
		logic [3:0] res;
		res = 4'h0;
		for (int i = 5; i >= 0; i--) begin
			if (d[i] && r[4*i]) begin
				res = {1'b1, r[4*i+1 +: 3]};
			end
		end
		return res;
	endfunction : pick_rdi

	function automatic logic wr_hit(input logic [13:0] a, input logic [13:0] b, input logic w);
		return w && (a == b);
	endfunction : wr_hit

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;
	assign atm_ready = atm_ready_q;
	assign ppp_ready = ppp_ready_q;
	assign spe_out = spe_out_q;
	assign ptr_cmd = ptr_cmd_q;
	assign ptr_ais = ptr_ais_q;

	// APB decode; zero wait states, answer registered in the setup cycle
	assign idx = paddr[15:2];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
	assign ais_q = ctrl0_q[`POH_CTRL0_AIS];
	assign ais_next = wr_hit(idx, `POH_IDX_CTRL0, wr_en) ? pwdata[`POH_CTRL0_AIS] : ais_q;

	always_comb begin
		hit = 1'b1;
		rd_word = 32'h00000000;
		case (idx)
			`POH_IDX_CTRL0: rd_word = {24'h000000, ctrl0_q};
			`POH_IDX_B3_MASK: rd_word = {24'h000000, b3_mask_q};
			`POH_IDX_RDI_CODE2: rd_word = {24'h000000, rdi_code_q[23:16]};
			`POH_IDX_RDI_CODE1: rd_word = {24'h000000, rdi_code_q[15:8]};
			`POH_IDX_RDI_CODE0: rd_word = {24'h000000, rdi_code_q[7:0]};
			`POH_IDX_BYTES_A: rd_word = bytes_a_q;
			`POH_IDX_BYTES_B: rd_word = bytes_b_q;
			`POH_IDX_FORCE: rd_word = {27'h0000000, force_q[4:3], pend_q};
			`POH_IDX_STATUS: rd_word = {5'h00, rdi_val, b3_q, 8'h00, rx_defects, ext_sync2_q, ais_q};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			if (setup && !pwrite) begin
				prdata_q <= hit ? rd_word : 32'h00000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q <= `POH_RST_CTRL0;
			b3_mask_q <= `POH_RST_B3_MASK;
			rdi_code_q <= {3{`POH_RST_RDI_CODE}};
			bytes_a_q <= `POH_RST_BYTES_A;
			bytes_b_q <= `POH_RST_BYTES_B;
			force_q <= 5'h00;
		end else if (wr_en) begin
			case (idx)
				`POH_IDX_CTRL0: ctrl0_q <= pwdata[7:0] & `POH_CTRL0_RW_MASK;
				`POH_IDX_B3_MASK: b3_mask_q <= pwdata[7:0];
				`POH_IDX_RDI_CODE2: rdi_code_q[23:16] <= pwdata[7:0];
				`POH_IDX_RDI_CODE1: rdi_code_q[15:8] <= pwdata[7:0];
				`POH_IDX_RDI_CODE0: rdi_code_q[7:0] <= pwdata[7:0];
				`POH_IDX_BYTES_A: bytes_a_q <= pwdata;
				`POH_IDX_BYTES_B: bytes_b_q <= pwdata;
				`POH_IDX_FORCE: force_q <= pwdata[4:0];
				default: force_q <= force_q;
			endcase
		end
	end

	// External RDI request is a pin; two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync1_q <= 1'b0;
			ext_sync2_q <= 1'b0;
		end else begin
			ext_sync1_q <= ext_path_overhead_in;
			ext_sync2_q <= ext_sync1_q;
		end
	end

	// SPE position: row 0..8, column 0..260; column 0 is path overhead
	assign last_col = (col_q == 9'(COLS - 1));
	assign last_row = (row_q == 4'(ROWS - 1));
	assign frame_end = last_col && last_row;
	assign sof = (row_q == 4'h0) && (col_q == 9'h000);
	assign col_d = last_col ? 9'h000 : col_q + 9'h001;
	assign row_d = !last_col ? row_q : (last_row ? 4'h0 : row_q + 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_q <= 4'h0;
			col_q <= 9'h000;
		end else begin
			row_q <= row_d;
			col_q <= col_d;
		end
	end

	// RDI source: 00 auto, 01 software, 10 external pin gates software code
	always_comb begin
		auto_rdi = pick_rdi(rx_defects, rdi_code_q);
		case (ctrl0_q[`POH_CTRL0_RDI_LSB +: 2])
			2'b00: rdi_val = auto_rdi[2:0];
			2'b10: rdi_val = ext_sync2_q ? bytes_b_q[3:1] : 3'h0;
			default: rdi_val = bytes_b_q[3:1];
		endcase
		rei_val = (ctrl0_q[`POH_CTRL0_REI_LSB +: 2] == 2'b00) ? rei_cnt_q : bytes_b_q[7:4];
		// G1 bits 5-7 in transmission order are the low bits here
		g1_byte = {rei_val, rdi_val, 1'b0};
	end

	always_comb begin
		case (row_q)
			4'h0: poh_byte = bytes_a_q[31:24];
			4'h1: poh_byte = b3_q ^ b3_mask_q;
			4'h2: poh_byte = ctrl0_q[`POH_CTRL0_C2_TYPE] ? ext_poh_byte : bytes_a_q[23:16];
			4'h3: poh_byte = g1_byte;
			4'h4: poh_byte = ctrl0_q[`POH_CTRL0_F2_TYPE] ? ext_poh_byte : bytes_a_q[15:8];
			4'h5: poh_byte = bytes_a_q[7:0];
			4'h6: poh_byte = bytes_b_q[31:24];
			4'h7: poh_byte = bytes_b_q[23:16];
			default: poh_byte = bytes_b_q[15:8];
		endcase
	end

	assign take_atm = atm_ready_q && atm_valid;
	assign take_ppp = ppp_ready_q && ppp_valid;

	always_comb begin
		if (ais_q) begin
			byte_d = 8'hff;
		end else if (col_q == 9'h000) begin
			byte_d = poh_byte;
		end else if (take_atm) begin
			byte_d = atm_data;
		end else if (take_ppp) begin
			byte_d = ppp_data;
		end else begin
			byte_d = `POH_FILL_BYTE;
		end
	end

	// Ready is set a cycle ahead, so only payload slots ever see it high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			atm_ready_q <= 1'b0;
			ppp_ready_q <= 1'b0;
		end else begin
			atm_ready_q <= (col_d != 9'h000) && !ais_next && !force_q[`POH_FORCE_PPP];
			ppp_ready_q <= (col_d != 9'h000) && !ais_next && force_q[`POH_FORCE_PPP];
		end
	end

	// Parity runs over the transmitted bytes, mask applied only at insertion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 8'h00;
			b3_q <= 8'h00;
		end else if (frame_end) begin
			acc_q <= 8'h00;
			b3_q <= acc_q ^ byte_d;
		end else begin
			acc_q <= acc_q ^ byte_d;
		end
	end

	// New error count wins over the clear when G1 goes out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rei_cnt_q <= 4'h0;
		end else if (rx_b3_err_stb) begin
			rei_cnt_q <= (rx_b3_err_cnt > `POH_REI_MAX) ? `POH_REI_MAX : rx_b3_err_cnt;
		end else if ((row_q == 4'h3) && (col_q == 9'h000)) begin
			rei_cnt_q <= 4'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spe_out_q <= '0;
			ptr_ais_q <= 1'b0;
		end else begin
			spe_out_q <= '{valid: 1'b1, sof: sof, poh: (col_q == 9'h000), data: byte_d};
			ptr_ais_q <= ais_q;
		end
	end

	// Pointer forces wait for frame start; a write in that cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 3'h0;
			ptr_cmd_q <= '0;
		end else begin
			if (sof) begin
				ptr_cmd_q <= '{inc: pend_q[0], dec: pend_q[1] && !pend_q[0],
					ndf: pend_q[2] || force_q[`POH_FORCE_NDF_CONT]};
			end else begin
				ptr_cmd_q <= '0;
			end
			if (wr_hit(idx, `POH_IDX_FORCE, wr_en)) begin
				pend_q <= (sof ? {1'b0, pend_q[1] && pend_q[0], 1'b0} : pend_q) | pwdata[2:0];
			end else if (sof) begin
				pend_q <= {1'b0, pend_q[1] && pend_q[0], 1'b0};
			end
		end
	end

	a_b3_insert: assert property (@(posedge pclk) disable iff (!presetn)
		(row_q == 4'h1 && col_q == 9'h000 && !ais_q)
		|=> spe_out_q.data == ($past(b3_q) ^ $past(b3_mask_q)))
		else $error("B3 byte is not parity xor mask");

	a_b3_parity: assert property (@(posedge pclk) disable iff (!presetn)
		frame_end |=> b3_q == $past(acc_q ^ byte_d))
		else $error("B3 parity not latched at frame end");

	a_ais_ones: assert property (@(posedge pclk) disable iff (!presetn)
		ais_q |=> spe_out_q.data == 8'hff && ptr_ais_q)
		else $error("AIS frame byte not all ones");

	a_ais_no_cells: assert property (@(posedge pclk) disable iff (!presetn)
		$past(ais_next) |-> !atm_ready_q && !ppp_ready_q)
		else $error("Upstream ready during path AIS");

	a_poh_column: assert property (@(posedge pclk) disable iff (!presetn)
		(col_q == 9'h000) |-> !atm_ready_q && !ppp_ready_q ##1 spe_out_q.poh)
		else $error("Overhead column mishandled");

	a_cell_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(take_atm && !ais_q) |=> spe_out_q.data == $past(atm_data) && !spe_out_q.poh)
		else $error("ATM byte not placed in payload");

	a_rdi_auto: assert property (@(posedge pclk) disable iff (!presetn)
		(row_q == 4'h3 && col_q == 9'h000 && !ais_q && ctrl0_q[4:3] == 2'b00)
		|=> spe_out_q.data[3:1] == $past(auto_rdi[2:0]))
		else $error("G1 RDI bits differ from auto code");

	a_plm_disable: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_defects == 6'b010000 && !rdi_code_q[16]) |-> auto_rdi == 4'h0)
		else $error("PLM raised RDI while disabled");

	a_plm_code: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_defects == 6'b010000 && rdi_code_q[16]) |-> auto_rdi == {1'b1, rdi_code_q[19:17]})
		else $error("PLM RDI code not taken from field");

	a_sof_period: assert property (@(posedge pclk) disable iff (!presetn)
		frame_end |=> sof ##1 spe_out_q.sof)
		else $error("Frame does not restart after last byte");

endmodule : sts3c_path_overhead_tx
`default_nettype wire

// ### poh_far_end.sv
// Purpose: Far-end path terminator model fed by the SPE byte stream.
// Assumes: One SPE byte per pclk; sof marks row 0 of column 0.
// Notes:   Keeps last POH column, parity of the prior SPE, all-ones flag.
`timescale 1ns/10ps
`default_nettype none
module poh_far_end (
	input wire logic pclk,
	input wire logic presetn,
	input wire sts3c_poh_tx_pkg::spe_out_t spe,
	output logic [8:0][7:0] poh_q,
	output logic [7:0] bip_q,
	output logic ones_q,
	output int frames_q
);
	logic [7:0] acc_q;
	logic all_q;
	logic [3:0] row_q;
	logic [3:0] idx;
	assign idx = spe.sof ? 4'h0 : row_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 8'h00;
			bip_q <= 8'h00;
			all_q <= 1'b1;
			ones_q <= 1'b0;
			row_q <= 4'h0;
			poh_q <= '0;
			frames_q <= 0;
		end else if (spe.valid) begin
			// Parity runs over every byte as sent, POH included
			acc_q <= spe.sof ? spe.data : acc_q ^ spe.data;
			all_q <= (spe.sof | all_q) & (spe.data == 8'hff);
			if (spe.sof) begin
				bip_q <= acc_q;
				ones_q <= all_q;
			end
			if (spe.poh) begin
				poh_q[idx] <= spe.data;
				row_q <= idx + 4'h1;
				if (idx == 4'h8)
					frames_q <= frames_q + 1;
			end
		end
	end
endmodule : poh_far_end
`default_nettype wire

// ### tb_sts3c_path_overhead_tx.sv
// Purpose: Self-checking bench for the STS-3c transmit POH generator.
// Assumes: Short SPE of 9 rows by 8 columns to keep frames quick.
// Notes:   Expected POH bytes are judged after whole frames pass.
`timescale 1ns/10ps
`default_nettype none
`include "sts3c_poh_tx_map.svh"
module tb_sts3c_path_overhead_tx;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd, a, b;
	logic [7:0] atm_data, ppp_data, ext_byte, d_q, v, m;
	logic atm_valid, atm_ready, ppp_valid, ppp_ready, ext_in, b3_stb;
	logic ppp_on, tk_q, run, ptr_ais, ones;
	logic [3:0] b3_cnt;
	logic [2:0] c;
	logic [8:0][7:0] poh;
	logic [7:0] bip;
	sts3c_poh_tx_pkg::rx_defects_t defects;
	sts3c_poh_tx_pkg::spe_out_t spe;
	sts3c_poh_tx_pkg::ptr_cmd_t pcmd;
	int frames, num_errors, compares, cyc, p;
	int pc[3];
	sts3c_path_overhead_tx #(.ROWS(9), .COLS(8)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .atm_data(atm_data),
		.atm_valid(atm_valid), .atm_ready(atm_ready), .ppp_data(ppp_data),
		.ppp_valid(ppp_valid), .ppp_ready(ppp_ready), .rx_defects(defects),
		.rx_b3_err_cnt(b3_cnt), .rx_b3_err_stb(b3_stb), .ext_path_overhead_in(ext_in),
		.ext_poh_byte(ext_byte), .spe_out(spe), .ptr_ais(ptr_ais), .ptr_cmd(pcmd));
	poh_far_end far_u (.pclk(pclk), .presetn(presetn), .spe(spe), .poh_q(poh),
		.bip_q(bip), .ones_q(ones), .frames_q(frames));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		atm_data <= 8'($urandom);
		ppp_data <= 8'($urandom);
		atm_valid <= run && ($urandom % 4 != 0);
		ppp_valid <= run && ($urandom % 4 != 0);
		tk_q <= ppp_on ? ppp_valid && ppp_ready : atm_valid && atm_ready;
		d_q <= ppp_on ? ppp_data : atm_data;
		if (pcmd.inc) pc[0]++;
		if (pcmd.dec) pc[1]++;
		if (pcmd.ndf) pc[2]++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	// A taken byte must be the next payload byte out
	always @(negedge pclk)
		if (tk_q) begin
			compares++;
			if (spe.data !== d_q || spe.poh !== 1'b0) begin
				num_errors++;
				$display("mismatch at %0t: payload byte", $time);
			end
		end
	// Reported REI is the received error count, capped at the REI maximum
	function automatic logic [3:0] rei_exp(input logic [3:0] n);
		return (n > `POH_REI_MAX) ? `POH_REI_MAX : n;
	endfunction : rei_exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench timeout ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wf(input int n);
		int f;
		f = frames + n;
		while (frames < f) @(posedge pclk);
	endtask : wf
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	initial begin
		void'($urandom(10769));
		{presetn, psel, penable, pwrite, atm_valid, ppp_valid, b3_stb, ext_in} = '0;
		{run, ppp_on, tk_q, paddr, pwdata, atm_data, ppp_data, ext_byte, b3_cnt} = '0;
		{defects, cyc, num_errors, compares} = '0;
		pc = '{0, 0, 0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `POH_IDX_B3_MASK, 0);
		chk(rd, 32'h0, "mask reset");
		apb(1, `POH_IDX_CTRL0, 32'hff);
		apb(0, `POH_IDX_CTRL0, 0);
		chk(rd, 32'hfd, "ctrl0 rw");
		apb(1, `POH_IDX_CTRL0, 0);
		apb(0, 14'h0100, 0);
		chk({31'h0, err}, 32'h1, "unmapped");
		$display("test registers done");
		run = 1'b1;
		for (int k = 0; k < 4; k++) begin
			m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			apb(1, `POH_IDX_B3_MASK, {24'h0, m});
			wf(2);
			chk(poh[1], bip ^ m, "b3");
		end
		apb(1, `POH_IDX_B3_MASK, 0);
		$display("test parity done");
		a = $urandom;
		b = $urandom;
		apb(1, `POH_IDX_BYTES_A, a);
		apb(1, `POH_IDX_BYTES_B, b);
		wf(2);
		chk({poh[0], poh[2], poh[4], poh[5]}, a, "j1 c2 f2 h4");
		chk({8'h0, poh[6], poh[7], poh[8]}, {8'h0, b[31:8]}, "z bytes");
		ext_byte <= 8'($urandom);
		apb(1, `POH_IDX_CTRL0, 32'h84);
		wf(2);
		chk({poh[2], poh[4]}, {2{ext_byte}}, "c2 f2 ext");
		apb(1, `POH_IDX_CTRL0, 0);
		$display("test overhead done");
		for (int i = 0; i < 6; i++) begin
			c = 3'($urandom % 7 + 1);
			v = i[0] ? {c, 5'h10} : {4'h0, c, 1'b1};
			apb(1, `POH_IDX_RDI_CODE0 - 14'(i / 2), {24'h0, v});
			defects <= 6'(1 << i);
			wf(2);
			chk(poh[3][3:1], c, "auto rdi");
			apb(1, `POH_IDX_RDI_CODE0 - 14'(i / 2), {24'h0, v & 8'hee});
			wf(2);
			chk(poh[3][3:1], 0, "rdi off");
		end
		defects <= '0;
		$display("test auto rdi done");
		apb(1, `POH_IDX_BYTES_B, {b[31:8], 8'h9a});
		for (int j = 0; j < 3; j++) begin
			apb(1, `POH_IDX_CTRL0, (j == 0) ? 32'h08 : 32'h10);
			ext_in <= (j == 2);
			wf(2);
			chk(poh[3][3:1], (j == 1) ? 3'h0 : 3'h5, "sw rdi");
		end
		apb(1, `POH_IDX_CTRL0, 32'h20);
		wf(2);
		chk(poh[3][7:4], 4'h9, "sw rei");
		apb(1, `POH_IDX_CTRL0, 0);
		ext_in <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 8'h05 : (k == 1) ? 8'h0f : 8'($urandom % 16);
			wf(1);
			b3_cnt <= v[3:0];
			b3_stb <= 1'b1;
			@(posedge pclk);
			b3_stb <= 1'b0;
			wf(1);
			chk(poh[3][7:4], rei_exp(v[3:0]), "auto rei");
		end
		wf(1);
		chk(poh[3][7:4], 4'h0, "rei clear");
		$display("test rdi rei done");
		apb(1, `POH_IDX_CTRL0, 32'h01);
		wf(3);
		@(negedge pclk);
		chk({31'h0, ones}, 32'h1, "ais spe");
		chk({ptr_ais, atm_ready, ppp_ready}, 3'b100, "ais ptr ready");
		apb(1, `POH_IDX_CTRL0, 0);
		wf(3);
		chk({31'h0, ones}, 32'h0, "ais off");
		$display("test ais done");
		for (int j = 0; j < 3; j++) begin
			apb(1, `POH_IDX_FORCE, 32'(1 << j));
			wf(2);
			chk(pc[j], 1, "ptr cmd");
		end
		// Continuous NDF marks every frame start
		apb(1, `POH_IDX_FORCE, 32'h08);
		wf(1);
		p = pc[2];
		wf(2);
		chk(pc[2] - p, 2, "ndf cont");
		apb(1, `POH_IDX_FORCE, 32'h10);
		ppp_on <= 1'b1;
		wf(3);
		$display("test ptr ppp done");
		finish_test();
	end
endmodule : tb_sts3c_path_overhead_tx
`default_nettype wire
